/* File: core/cfgpin_clkdiv.sv */
// Binary clock divider producing three halving clock outputs, stopped in suspend
`timescale 1ns/1ns
`default_nettype none
module cfgpin_clkdiv #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Control and outputs
   input  wire logic         stop,
   output var  logic [W-1:0] div_q
);

   // Bit k toggles at clk / 2^(k+1); held low while stopped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_q <= '0;
      end
      else if (ce)
      begin
         if (stop)
            div_q <= '0;
         else
            div_q <= div_q + 1'b1;
      end
   end

endmodule
`default_nettype wire

/* File: core/cfgpin_led_stretch.sv */
// Retriggerable low pulse stretcher for one activity LED
`timescale 1ns/1ns
`default_nettype none
module cfgpin_led_stretch #(
   parameter int CNT_W = 17,
   parameter logic [CNT_W-1:0] HOLD = 17'h186A0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Activity in, LED out
   input  wire logic trig,
   output var  logic led_n_q
);

   logic [CNT_W-1:0] cnt_q;

   // Counter restarts on every burst of activity
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
      end
      else if (ce)
      begin
         if (trig)
            cnt_q <= HOLD;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         led_n_q <= 1'b1;
      end
      else if (ce)
      begin
         led_n_q <= !(trig || cnt_q > 1);
      end
   end

endmodule
`default_nettype wire

/* File: core/cfgpin_pkg.sv */
// Constants, codes and carrier types of the configurable pin function selector
package cfgpin_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NPINS     = 4;
   localparam int SEL_W     = 5;
   localparam int CLKDIV_W  = 3;
   localparam int LEDCNT_W  = 17;

   typedef logic [SEL_W-1:0] cfgpin_sel_t;

   // ----------------------------------------------------------------
   // Function codes held in non-volatile configuration
   // ----------------------------------------------------------------
   localparam cfgpin_sel_t SEL_TRISTATE   = 5'h00;
   localparam cfgpin_sel_t SEL_DRIVE1     = 5'h01;
   localparam cfgpin_sel_t SEL_DRIVE0     = 5'h02;
   localparam cfgpin_sel_t SEL_RS485_DRIVE_ENABLE      = 5'h03;
   localparam cfgpin_sel_t SEL_POWER_ENABLE_N      = 5'h04;
   localparam cfgpin_sel_t SEL_TX_ACTIVITY_LED_N      = 5'h05;
   localparam cfgpin_sel_t SEL_RX_ACTIVITY_LED_N      = 5'h06;
   localparam cfgpin_sel_t SEL_ANYLED     = 5'h07;
   localparam cfgpin_sel_t SEL_SLEEP      = 5'h08;
   localparam cfgpin_sel_t SEL_CLK_FAST   = 5'h09;
   localparam cfgpin_sel_t SEL_CLK_MID    = 5'h0A;
   localparam cfgpin_sel_t SEL_CLK_SLOW   = 5'h0B;
   localparam cfgpin_sel_t SEL_GPIO       = 5'h0C;
   localparam cfgpin_sel_t SEL_CHARGER    = 5'h0D;
   localparam cfgpin_sel_t SEL_CHARGER_N  = 5'h0E;
   localparam cfgpin_sel_t SEL_BB_WR      = 5'h0F;
   localparam cfgpin_sel_t SEL_BB_RD      = 5'h10;
   localparam cfgpin_sel_t SEL_VBUS       = 5'h11;
   localparam cfgpin_sel_t SEL_TIMESTAMP  = 5'h12;
   localparam cfgpin_sel_t SEL_KEEP_AWAKE = 5'h13;

   // Selections held until configuration is latched
   localparam cfgpin_sel_t [NPINS-1:0] SEL_RESET = {SEL_SLEEP, SEL_TX_ACTIVITY_LED_N, SEL_RX_ACTIVITY_LED_N, SEL_RS485_DRIVE_ENABLE};

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_PINSEL = 4'h0;
   localparam logic [3:0] ADDR_GPIO   = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam int PINSEL_PD_BIT   = 20;
   localparam int GPIO_DIR_LSB    = 4;
   localparam int STAT_VBUS_BIT   = 4;
   localparam int STAT_AWAKE_BIT  = 5;
   localparam int STAT_SUSP_BIT   = 6;
   localparam int STAT_CONF_BIT   = 7;
   localparam logic [3:0] GPIO_OUT_RESET = 4'h0;
   localparam logic [3:0] GPIO_DIR_RESET = 4'h0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int LED_HOLD_NS   = 10_000_000;
   localparam int LED_HOLD_CYC  = (LED_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic o;
      logic oe;
      logic pu;
      logic pd;
   } cfgpin_pad_s;

   typedef struct packed {
      logic usb_configured;
      logic usb_suspend;
      logic uart_tx_busy;
      logic usb_tx_act;
      logic usb_rx_act;
      logic charger_det;
      logic bb_wr_n;
      logic bb_rd_n;
      logic usb_sof;
   } cfgpin_stat_s;

endpackage

/* File: core/cfgpin_top.sv */
// Configurable auxiliary pin function selector with Avalon-MM register slave
//
// Functional notes
// - Each pin can be tri-stated or driven to a fixed high or low.
// - Any function on any of four pins; selection comes from non-volatile configuration.
// - Transmit-enable pin drives RS485 driver enable while serial data is sent.
// - Power-enable pin low once configured by host, high during suspend.
// - Transmit LED pin pulses low on USB transmit traffic.
// - Receive LED pin pulses low on USB receive traffic.
// - Combined LED pin pulses low on any USB traffic.
// - Sleep pin low during USB suspend, high otherwise.
// - Three divided clock outputs, stopped during USB suspend.
// - Each pin individually usable as host-controlled general purpose I/O.
// - Charger pin high when a dedicated charger is detected.
// - Inverted charger pin drives the complement of charger detect.
// - Write-strobe pin outputs the active-low bit-bang write strobe.
// - Read-strobe pin outputs the active-low bit-bang read strobe.
// - VBUS-sense pin is an input reporting VBUS presence.
// - Time-stamp pin toggles once per start-of-frame.
// - Keep-awake pin is an active-low input blocking suspend on unplug.
// - Default functions: transmit enable, receive LED, transmit LED, sleep.
// - Input pins pulled up weakly; optional gentle pull-down during suspend.
`timescale 1ns/1ns
`default_nettype none
module cfgpin_top #(
   parameter int LED_HOLD_CYC = cfgpin_pkg::LED_HOLD_CYC
) (
   // Clock, reset, enable
   input  wire logic                                            clk,
   input  wire logic                                            rst,
   input  wire logic                                            ce,
   // Avalon-MM slave
   input  wire logic [3:0]                                      avs_address,
   input  wire logic                                            avs_read,
   input  wire logic                                            avs_write,
   input  wire logic [31:0]                                     avs_writedata,
   input  wire logic [3:0]                                      avs_byteenable,
   output var  logic [31:0]                                     avs_readdata,
   output logic                                                 avs_waitrequest,
   // Non-volatile configuration
   input  wire cfgpin_pkg::cfgpin_sel_t [cfgpin_pkg::NPINS-1:0] nv_sel,
   input  wire logic                                            nv_pulldown_en,
   // Internal status and strobes
   input  wire cfgpin_pkg::cfgpin_stat_s                        stat,
   // Pads
   input  wire logic [cfgpin_pkg::NPINS-1:0]                    pad_i,
   output var  cfgpin_pkg::cfgpin_pad_s [cfgpin_pkg::NPINS-1:0] pad,
   // Sensed inputs to the core
   output logic                                                 vbus_present,
   output logic                                                 keep_awake
);

   localparam int N = cfgpin_pkg::NPINS;

   // ----------------------------------------------------------------
   // Configuration latch
   // ----------------------------------------------------------------
   cfgpin_pkg::cfgpin_sel_t [N-1:0] sel_q;
   logic                            pd_opt_q;
   logic                            done_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sel_q    <= cfgpin_pkg::SEL_RESET;
         pd_opt_q <= 1'b0;
         done_q   <= 1'b0;
      end
      else if (ce && !done_q)
      begin
         sel_q    <= nv_sel;
         pd_opt_q <= nv_pulldown_en;
         done_q   <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave: one wait state per access
   // ----------------------------------------------------------------
   logic       req;
   logic       ack_q;
   logic [3:0] gpio_out_q;
   logic [3:0] gpio_dir_q;
   logic [31:0] rd_d;

   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !(ack_q && ce);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ack_q <= 1'b0;
      else if (ce)
         ack_q <= req && !ack_q;
   end

   // Host bit-bang levels and directions
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gpio_out_q <= cfgpin_pkg::GPIO_OUT_RESET;
         gpio_dir_q <= cfgpin_pkg::GPIO_DIR_RESET;
      end
      else if (ce && avs_write && ack_q && avs_address == cfgpin_pkg::ADDR_GPIO && avs_byteenable[0])
      begin
         gpio_out_q <= avs_writedata[3:0];
         gpio_dir_q <= avs_writedata[cfgpin_pkg::GPIO_DIR_LSB +: 4];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      unique case (avs_address)
         cfgpin_pkg::ADDR_PINSEL:
         begin
            rd_d[N*cfgpin_pkg::SEL_W-1:0]       = sel_q;
            rd_d[cfgpin_pkg::PINSEL_PD_BIT]     = pd_opt_q;
         end
         cfgpin_pkg::ADDR_GPIO:
         begin
            rd_d[3:0]                           = gpio_out_q;
            rd_d[cfgpin_pkg::GPIO_DIR_LSB +: 4] = gpio_dir_q;
         end
         cfgpin_pkg::ADDR_STATUS:
         begin
            rd_d[N-1:0]                         = pad_i;
            rd_d[cfgpin_pkg::STAT_VBUS_BIT]     = vbus_present;
            rd_d[cfgpin_pkg::STAT_AWAKE_BIT]    = keep_awake;
            rd_d[cfgpin_pkg::STAT_SUSP_BIT]     = stat.usb_suspend;
            rd_d[cfgpin_pkg::STAT_CONF_BIT]     = stat.usb_configured;
         end
         default:
         begin
            rd_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (ce && avs_read && !ack_q)
         avs_readdata <= rd_d;
   end

   // ----------------------------------------------------------------
   // Shared sources
   // ----------------------------------------------------------------
   logic                tx_led_n;
   logic                rx_led_n;
   logic                any_led_n;
   logic [cfgpin_pkg::CLKDIV_W-1:0] div;
   logic                stamp_q;

   cfgpin_led_stretch #(
      .CNT_W (cfgpin_pkg::LEDCNT_W),
      .HOLD  (cfgpin_pkg::LEDCNT_W'(LED_HOLD_CYC))
   ) u_tx_led (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .trig    (stat.usb_tx_act),
      .led_n_q (tx_led_n)
   );

   cfgpin_led_stretch #(
      .CNT_W (cfgpin_pkg::LEDCNT_W),
      .HOLD  (cfgpin_pkg::LEDCNT_W'(LED_HOLD_CYC))
   ) u_rx_led (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .trig    (stat.usb_rx_act),
      .led_n_q (rx_led_n)
   );

   cfgpin_led_stretch #(
      .CNT_W (cfgpin_pkg::LEDCNT_W),
      .HOLD  (cfgpin_pkg::LEDCNT_W'(LED_HOLD_CYC))
   ) u_any_led (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .trig    (stat.usb_tx_act || stat.usb_rx_act),
      .led_n_q (any_led_n)
   );

   cfgpin_clkdiv #(
      .W (cfgpin_pkg::CLKDIV_W)
   ) u_div (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .stop  (stat.usb_suspend),
      .div_q (div)
   );

   // Start-of-frame toggle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         stamp_q <= 1'b0;
      else if (ce && stat.usb_sof)
         stamp_q <= !stamp_q;
   end

   // ----------------------------------------------------------------
   // Per-pin function mux
   // ----------------------------------------------------------------
   logic [N-1:0] vbus_hit;
   logic [N-1:0] awake_hit;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_pin
         cfgpin_pkg::cfgpin_pad_s pad_d;
         logic                    is_in;

         always_comb
         begin
            pad_d    = '0;
            pad_d.oe = 1'b1;
            unique case (sel_q[gi])
               cfgpin_pkg::SEL_TRISTATE:   pad_d.oe = 1'b0;
               cfgpin_pkg::SEL_DRIVE1:     pad_d.o  = 1'b1;
               cfgpin_pkg::SEL_DRIVE0:     pad_d.o  = 1'b0;
               cfgpin_pkg::SEL_RS485_DRIVE_ENABLE:      pad_d.o  = stat.uart_tx_busy;
               cfgpin_pkg::SEL_POWER_ENABLE_N:      pad_d.o  = !(stat.usb_configured && !stat.usb_suspend);
               cfgpin_pkg::SEL_TX_ACTIVITY_LED_N:      pad_d.o  = tx_led_n;
               cfgpin_pkg::SEL_RX_ACTIVITY_LED_N:      pad_d.o  = rx_led_n;
               cfgpin_pkg::SEL_ANYLED:     pad_d.o  = any_led_n;
               cfgpin_pkg::SEL_SLEEP:      pad_d.o  = !stat.usb_suspend;
               cfgpin_pkg::SEL_CLK_FAST:   pad_d.o  = div[0];
               cfgpin_pkg::SEL_CLK_MID:    pad_d.o  = div[1];
               cfgpin_pkg::SEL_CLK_SLOW:   pad_d.o  = div[2];
               cfgpin_pkg::SEL_GPIO:
               begin
                  pad_d.o  = gpio_out_q[gi];
                  pad_d.oe = gpio_dir_q[gi];
               end
               cfgpin_pkg::SEL_CHARGER:    pad_d.o  = stat.charger_det;
               cfgpin_pkg::SEL_CHARGER_N:  pad_d.o  = !stat.charger_det;
               cfgpin_pkg::SEL_BB_WR:      pad_d.o  = stat.bb_wr_n;
               cfgpin_pkg::SEL_BB_RD:      pad_d.o  = stat.bb_rd_n;
               cfgpin_pkg::SEL_VBUS:       pad_d.oe = 1'b0;
               cfgpin_pkg::SEL_TIMESTAMP:  pad_d.o  = stamp_q;
               cfgpin_pkg::SEL_KEEP_AWAKE: pad_d.oe = 1'b0;
               default:                    pad_d.oe = 1'b0;
            endcase
            // Undriven pads pull up, or gently down in suspend when enabled
            is_in    = !pad_d.oe;
            pad_d.pd = is_in && pd_opt_q && stat.usb_suspend;
            pad_d.pu = is_in && !pad_d.pd;
         end

         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               pad[gi] <= '0;
            else if (ce)
               pad[gi] <= pad_d;
         end

         assign vbus_hit[gi]  = sel_q[gi] == cfgpin_pkg::SEL_VBUS && pad_i[gi];
         assign awake_hit[gi] = sel_q[gi] == cfgpin_pkg::SEL_KEEP_AWAKE && !pad_i[gi];
      end
   endgenerate

   assign vbus_present = |vbus_hit;
   assign keep_awake   = |awake_hit;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_SEL_FIXED: assert property (done_q |=> $stable(sel_q))
      else $error("pin select changed after latching");
   AST_TRISTATE: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_TRISTATE |=> !pad[0].oe)
      else $error("tri-state pin is driven");
   AST_DRIVE1: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_DRIVE1 |=> pad[0].oe && pad[0].o)
      else $error("drive-high pin not high");
   AST_DRIVE0: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_DRIVE0 |=> pad[0].oe && !pad[0].o)
      else $error("drive-low pin not low");
   AST_RS485_DRIVE_ENABLE: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_RS485_DRIVE_ENABLE |=> pad[0].o == $past(stat.uart_tx_busy))
      else $error("transmit enable does not follow serial transmit");
   AST_POWER_ENABLE_N: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_POWER_ENABLE_N && stat.usb_suspend |=> pad[0].o)
      else $error("power enable not high in suspend");
   AST_SLEEP: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_SLEEP |=> pad[0].o != $past(stat.usb_suspend))
      else $error("sleep pin wrong");
   AST_ANYLED: assert property ((ce && sel_q[0] == cfgpin_pkg::SEL_ANYLED && stat.usb_tx_act) ##1 ce |=> !pad[0].o)
      else $error("combined LED did not pulse low");
   AST_CLK_STOP: assert property ((ce && stat.usb_suspend && sel_q[0] == cfgpin_pkg::SEL_CLK_FAST) ##1 (ce && stat.usb_suspend) |=> !pad[0].o)
      else $error("clock output runs in suspend");
   AST_STAMP: assert property ((ce && sel_q[0] == cfgpin_pkg::SEL_TIMESTAMP && stat.usb_sof) ##1 ce |=> pad[0].o != $past(pad[0].o))
      else $error("time stamp did not toggle");
   AST_CHARGER: assert property (ce && sel_q[0] == cfgpin_pkg::SEL_CHARGER_N |=> pad[0].o != $past(stat.charger_det))
      else $error("inverted charger pin wrong");
   AST_PULLDOWN: assert property (pad[0].pd |-> !pad[0].oe && !pad[0].pu)
      else $error("pull-down on driven or pulled-up pad");
   AST_BUS_ACK: assert property (req && avs_waitrequest && ce ##1 ce |-> !avs_waitrequest)
      else $error("bus access not answered in one wait state");

   COV_LED: cover property (sel_q[1] == cfgpin_pkg::SEL_RX_ACTIVITY_LED_N && !pad[1].o);
   COV_GPIO: cover property (sel_q[0] == cfgpin_pkg::SEL_GPIO && pad[0].oe);
   COV_READ: cover property (avs_read && !avs_waitrequest);

endmodule
`default_nettype wire

/* File: testbench/cfgpin_board_model.sv */
// Board model: external drivers, pulls and pad levels
`timescale 1ns/1ns
`default_nettype none
module cfgpin_board_model (
   // Clock
   input  wire logic                          clk,
   // Selector pads
   input  wire cfgpin_pkg::cfgpin_pad_s [3:0] pad,
   // External drivers
   input  wire logic [3:0]                    ext_en,
   input  wire logic [3:0]                    ext_lvl,
   // Wire levels
   output var  logic [3:0]                    pad_i
);
   logic flip_q = 1'b0;
   // Floating lines change level every cycle
   always @(posedge clk)
      flip_q <= ~flip_q;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (pad[i].oe)
            pad_i[i] = pad[i].o;
         else if (ext_en[i])
            pad_i[i] = ext_lvl[i];
         else if (pad[i].pd)
            pad_i[i] = 1'b0;
         else if (pad[i].pu)
            pad_i[i] = 1'b1;
         else
            pad_i[i] = flip_q;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/config_pin_function_select_bench.sv */
// Self-checking bench of the configurable pin selector
`timescale 1ns/1ns
`default_nettype none
module config_pin_function_select_bench;
   localparam int H = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   cfgpin_pkg::cfgpin_sel_t [3:0] nv_sel = '0;
   cfgpin_pkg::cfgpin_sel_t [3:0] sel_m;
   logic nv_pulldown_en = 1'b0;
   cfgpin_pkg::cfgpin_stat_s stat = '0;
   cfgpin_pkg::cfgpin_pad_s [3:0] pad;
   logic [3:0] pad_i, pi_s, vm, km, ck_m;
   logic [3:0] ext_en = 4'h0;
   logic [3:0] ext_lvl = 4'h0;
   logic [3:0] exp_m [4];
   logic vbus_present, keep_awake, pd_m, sof1, busy = 1'b0;
   logic [2:0] sh;
   logic [7:0] gpio_m;
   logic [15:0] lfsr_q = 16'h005A;
   int failures = 0;
   int n_compared = 0;
   int live = 0;
   int since [3];

   always #50 clk = ~clk;
   cfgpin_top #(.LED_HOLD_CYC(H)) dut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .nv_sel(nv_sel), .nv_pulldown_en(nv_pulldown_en), .stat(stat), .pad_i(pad_i), .pad(pad),
      .vbus_present(vbus_present), .keep_awake(keep_awake));
   cfgpin_board_model board (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_i(pad_i));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic results();
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      busy = 1'b1;
      @(posedge clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (avs_waitrequest)
            pi_s = pad_i;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         check(32'h0, 32'h1, "bus timeout");
         results();
      end
      q = avs_readdata;
      if (wr && a == cfgpin_pkg::ADDR_GPIO && be[0])
         gpio_m = d[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      busy = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Random traffic and reference model
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      lfsr_q <= lfsr(lfsr_q);
      if (live > 3 && !busy)
      begin
         stat <= {lfsr_q[0] | lfsr_q[1], lfsr_q[7:3] == 5'h00 ? !stat.usb_suspend : stat.usb_suspend,
                  lfsr_q[2], lfsr_q[6:2] == 5'h1F, lfsr_q[11:7] == 5'h1F, lfsr_q[3], lfsr_q[4], lfsr_q[5],
                  lfsr_q[9:8] == 2'h0 && !stat.usb_sof};
         ext_en <= lfsr_q[15:12];
         ext_lvl <= lfsr_q[11:8];
      end
   end
   always @(negedge clk)
   begin
      logic [3:0] e;
      logic [2:0] nsh;
      logic [2:0] trig;
      logic sp;
      int k;
      if (rst)
      begin
         live = 0;
         sh = 3'h7;
         sof1 = 1'b0;
         since = '{100, 100, 100};
      end
      else
      begin
         for (int i = 0; i < 4 && live > 3; i++)
         begin
            e = {pad[i].o & ck_m[i], pad[i].oe, pad[i].pu, pad[i].pd};
            check(32'(e), 32'(exp_m[i]), "pad");
         end
         if (live > 3)
         begin
            check(32'(vbus_present), 32'(|(pad_i & vm)), "vbus");
            check(32'(keep_awake), 32'(|(~pad_i & km)), "awake");
         end
         live++;
         sp = stat.usb_suspend;
         nsh = {sh[1:0], sp};
         trig = {stat.usb_tx_act | stat.usb_rx_act, stat.usb_rx_act, stat.usb_tx_act};
         for (int i = 0; i < 4; i++)
         begin
            e = {pad[i].o, 3'h4};
            ck_m[i] = 1'b1;
            k = int'(sel_m[i]) - int'(cfgpin_pkg::SEL_TX_ACTIVITY_LED_N);
            case (sel_m[i])
               cfgpin_pkg::SEL_DRIVE1: e[3] = 1'b1;
               cfgpin_pkg::SEL_DRIVE0: e[3] = 1'b0;
               cfgpin_pkg::SEL_RS485_DRIVE_ENABLE: e[3] = stat.uart_tx_busy;
               cfgpin_pkg::SEL_POWER_ENABLE_N: e[3] = !(stat.usb_configured && !sp);
               cfgpin_pkg::SEL_SLEEP: e[3] = !sp;
               cfgpin_pkg::SEL_CHARGER: e[3] = stat.charger_det;
               cfgpin_pkg::SEL_CHARGER_N: e[3] = !stat.charger_det;
               cfgpin_pkg::SEL_BB_WR: e[3] = stat.bb_wr_n;
               cfgpin_pkg::SEL_BB_RD: e[3] = stat.bb_rd_n;
               cfgpin_pkg::SEL_TIMESTAMP: e[3] = pad[i].o ^ sof1;
               cfgpin_pkg::SEL_TX_ACTIVITY_LED_N, cfgpin_pkg::SEL_RX_ACTIVITY_LED_N, cfgpin_pkg::SEL_ANYLED:
               begin
                  e[3] = since[k] > H - 2;
                  ck_m[i] = since[k] < H - 1 || since[k] > H + 1;
               end
               cfgpin_pkg::SEL_CLK_FAST, cfgpin_pkg::SEL_CLK_MID, cfgpin_pkg::SEL_CLK_SLOW:
               begin
                  e[3] = nsh == 3'h0 && !pad[i].o;
                  ck_m[i] = nsh[1:0] == 2'h3 || (nsh == 3'h0 && sel_m[i] == cfgpin_pkg::SEL_CLK_FAST);
               end
               cfgpin_pkg::SEL_GPIO:
               begin
                  e = {gpio_m[i], gpio_m[i + 4], 2'h0};
                  ck_m[i] = gpio_m[i + 4];
               end
               default:
               begin
                  e[2] = 1'b0;
                  ck_m[i] = 1'b0;
               end
            endcase
            if (!e[2])
               e[1:0] = pd_m && sp ? 2'h1 : 2'h2;
            exp_m[i] = {e[3] & ck_m[i], e[2:0]};
         end
         for (int j = 0; j < 3; j++)
            since[j] = trig[j] ? 0 : since[j] + int'(since[j] < 100);
         sh = nsh;
         sof1 = stat.usb_sof;
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      #5000000;
      check(32'h0, 32'h1, "watchdog");
      results();
   end
   initial
   begin
      logic [31:0] q;
      for (int r = 0; r < 6; r++)
      begin
         // Freeze random traffic and enter reset before the model takes the new selection
         busy = 1'b1;
         @(posedge clk);
         rst <= 1'b1;
         for (int i = 0; i < 4; i++)
         begin
            sel_m[i] = r < 5 ? 5'(4 * r + i) : 5'(lfsr_q >> (3 * i));
            vm[i] = sel_m[i] == cfgpin_pkg::SEL_VBUS;
            km[i] = sel_m[i] == cfgpin_pkg::SEL_KEEP_AWAKE;
         end
         pd_m = r[0];
         gpio_m = 8'h00;
         stat <= '0;
         ext_en <= 4'h0;
         nv_sel <= sel_m;
         nv_pulldown_en <= pd_m;
         repeat (16) @(posedge clk);
         rst <= 1'b0;
         repeat (3) @(posedge clk);
         nv_sel <= ~sel_m;
         nv_pulldown_en <= !pd_m;
         bus(1'b1, cfgpin_pkg::ADDR_PINSEL, 32'hFFFFFFFF, 4'hF, q);
         bus(1'b1, 4'hC, 32'h000000FF, 4'hF, q);
         bus(1'b1, cfgpin_pkg::ADDR_GPIO, 32'h000000FF, 4'h0, q);
         bus(1'b0, cfgpin_pkg::ADDR_PINSEL, 32'h0, 4'hF, q);
         check(q, 32'({pd_m, sel_m}), "pinsel");
         for (int n = 0; n < 10; n++)
         begin
            bus(1'b0, n[0] ? 4'hC : cfgpin_pkg::ADDR_GPIO, 32'h0, 4'hF, q);
            check(q, n[0] ? 32'h0 : 32'(gpio_m), "gpio");
            bus(1'b1, cfgpin_pkg::ADDR_GPIO, 32'(lfsr_q), 4'hF, q);
            repeat (20) @(posedge clk);
            bus(1'b0, cfgpin_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
            check(q, 32'({stat.usb_configured, stat.usb_suspend, |(~pi_s & km), |(pi_s & vm), pi_s}),
                  "status");
         end
      end
      results();
   end
endmodule
`default_nettype wire
